// ==== tag_alarm_params.svh ====
// Purpose: offsets, field positions, reset values and codes of the tag command handler
// Assumes: 32-bit register port, byte addresses
// Notes:   multi-byte fields travel least significant byte first
`ifndef TAG_ALARM_PARAMS_SVH
`define TAG_ALARM_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_MASK        8'h08
`define OFS_ALARM_ID    8'h0c
`define OFS_CODE0       8'h10
`define OFS_CODE1       8'h14
`define OFS_CODE2       8'h18
`define OFS_UID_LO      8'h1c
`define OFS_UID_HI      8'h20

// ****************************************
// control bits
// ****************************************
`define CTRL_ALARM_MODE 0
`define CTRL_KEY_OK     1
`define CTRL_FREEZE     2
`define CTRL_ERASED     3
`define CTRL_GUARD      4

// ****************************************
// status bits
// ****************************************
`define ST_ID_STORED    0
`define ST_GUARD_SET    1
`define ST_ALARM_REPLY  2
`define ST_CODE_READ    3
`define ST_REFUSED      4
`define ST_WIDTH        5

// ****************************************
// frame fields and codes
// ****************************************
`define FLAG_ADDRESSED  5
`define FLAG_OPTION     6
`define RESP_OK         8'h00
`define RESP_ERROR      8'h01
`define CMD_ALARM_QUERY 8'ha5
`define CMD_GUARD       8'ha6
`define CMD_STORE_ID    8'ha7
`define CMD_FETCH_CODE  8'ha8
`define ERR_NO_KEY      8'h0f
`define ERR_FROZEN      8'h12
`define ALARM_ID_RESET  16'h0000
`define MAKER_CODE      8'h5a
`define RX_DEPTH        16
`define RESP_BYTES      13

`endif

// ==== tag_alarm_pkg.sv ====
// Purpose: shared types of the tag command handler
// Assumes: nothing
// Notes:   values live in tag_alarm_params.svh
package tag_alarm_pkg;
    typedef enum logic {tx_idle, tx_send} tx_state_t;
    typedef logic [7:0] byte_t;
endpackage : tag_alarm_pkg

// ==== reply_serializer.sv ====
// Purpose: sends a loaded reply one byte per clock, least significant byte first
// Assumes: line encoder appends crc16 after tx_last
// Notes:   loads while busy are ignored
`timescale 1ns/1ps
`include "tag_alarm_params.svh"

module reply_serializer (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic                        load,
    input  wire logic [8*`RESP_BYTES-1:0]    data,
    input  wire logic [3:0]                  len,
    output logic      [7:0]                  tx_byte,
    output logic                             tx_valid,
    output logic                             tx_last,
    output logic                             busy
);
    tag_alarm_pkg::tx_state_t    state_reg;
    logic [8*`RESP_BYTES-1:0]    data_reg;
    logic [3:0]                  left_reg;

    assign busy = (state_reg == tag_alarm_pkg::tx_send);

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= tag_alarm_pkg::tx_idle;
            data_reg  <= '0;
            left_reg  <= 4'h0;
            tx_byte   <= 8'h00;
            tx_valid  <= 1'b0;
            tx_last   <= 1'b0;
        end else begin
            case (state_reg)
                tag_alarm_pkg::tx_idle: begin
                    tx_valid <= 1'b0;
                    tx_last  <= 1'b0;
                    if (load && len != 4'h0) begin
                        data_reg  <= data;
                        left_reg  <= len;
                        state_reg <= tag_alarm_pkg::tx_send;
                    end
                end
                tag_alarm_pkg::tx_send: begin
                    tx_byte  <= data_reg[7:0];
                    tx_valid <= 1'b1;
                    tx_last  <= (left_reg == 4'h1);
                    data_reg <= data_reg >> 8;
                    left_reg <= left_reg - 4'h1;
                    if (left_reg == 4'h1) begin
                        state_reg <= tag_alarm_pkg::tx_idle;
                    end
                end
                default: state_reg <= tag_alarm_pkg::tx_idle;
            endcase
        end
    end
endmodule : reply_serializer

// ==== tag_alarm_cmd.sv ====
// Purpose: custom command handler for alarm query, guard, identifier write, code fetch
// Assumes: frame decoder delivers request bytes without crc, then end with crc result
// Notes:   replies leave without crc; the line encoder appends it
//
// Summary of operation
// [RQ1] option set, zero match length: reply flags and identifier if alarm mode on
// [RQ2] command a6 turns on key guarding of alarm set, reset and identifier; here it guards only the a7 identifier store
// [RQ3] reader must submit the alarm key before sending a6
// [RQ4] command a7 stores the carried 16-bit value as new alarm identifier
// [RQ5] with guarding on, reader must submit key before a7 or it fails
// [RQ6] command a8 returns stored product code unless it was erased
// [RQ7] guard and store commands answer error flags and code, or flags only
// [RQ8] nonzero match length selects identifier bytes; reply on match with mode on
// [RQ9] after freezing, alarm mode and identifier stay unchanged and changes refused
// [RQ10] requests with failed crc, other uid or other maker code are ignored
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "tag_alarm_params.svh"

module tag_alarm_cmd (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [7:0]   addr,
    input  wire logic [31:0]  wr_data,
    input  wire logic         wr_en,
    input  wire logic         rd_en,
    output logic      [31:0]  rd_data,
    output logic              irq,
    input  wire logic         rx_sof,
    input  wire logic         rx_valid,
    input  wire logic [7:0]   rx_byte,
    input  wire logic         rx_eof,
    input  wire logic         rx_crc_ok,
    output logic      [7:0]   tx_byte,
    output logic              tx_valid,
    output logic              tx_last
);
    // ****************************************
    // state
    // ****************************************
    tag_alarm_pkg::byte_t        rx_buf [0:`RX_DEPTH-1];
    logic [4:0]                  rx_cnt_reg;
    logic                        alarm_mode_reg;
    logic                        key_ok_reg;
    logic                        freeze_reg;
    logic                        erased_reg;
    logic                        guard_reg;
    logic [15:0]                 alarm_identifier_reg;
    logic [95:0]                 code_reg;
    logic [63:0]                 uid_reg;
    logic [`ST_WIDTH-1:0]        status_reg;
    logic [`ST_WIDTH-1:0]        mask_reg;
    logic [`ST_WIDTH-1:0]        events;
    logic                        load;
    logic [8*`RESP_BYTES-1:0]    resp;
    logic [3:0]                  resp_len;
    logic                        tx_busy;
    logic                        take;
    logic [3:0]                  p;
    logic                        do_guard;
    logic                        do_store;
    tag_alarm_pkg::byte_t        flags;

    function automatic logic [7:0] rx_at(input logic [3:0] idx);
        rx_at = rx_buf[idx];
    endfunction : rx_at

    // ****************************************
    // request capture
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_cnt_reg <= 5'h00;
        end else if (rx_sof) begin
            rx_cnt_reg <= 5'h00;
        end else if (rx_valid && rx_cnt_reg < 5'(`RX_DEPTH)) begin
            rx_buf[rx_cnt_reg[3:0]] <= rx_byte;
            rx_cnt_reg              <= rx_cnt_reg + 5'h01;
        end
    end

    // ****************************************
    // request decode
    // ****************************************
    always_comb begin
        flags    = rx_at(4'h0);
        p        = flags[`FLAG_ADDRESSED] ? 4'hb : 4'h3;
        take     = rx_eof && rx_crc_ok && !tx_busy && rx_cnt_reg >= 5'h03 // RQ10
                   && rx_at(4'h2) == `MAKER_CODE // RQ10
                   && (!flags[`FLAG_ADDRESSED] // RQ10
                       || {rx_at(4'ha), rx_at(4'h9), rx_at(4'h8), rx_at(4'h7),
                           rx_at(4'h6), rx_at(4'h5), rx_at(4'h4), rx_at(4'h3)} == uid_reg);
        load     = 1'b0;
        resp     = '0;
        resp_len = 4'h0;
        do_guard = 1'b0;
        do_store = 1'b0;
        events   = '0;
        if (take) begin
            case (rx_at(4'h1))
                `CMD_ALARM_QUERY: begin
                    if (flags[`FLAG_OPTION] && alarm_mode_reg) begin
                        if (rx_at(p) == 8'h00) begin
                            resp[23:0] = {alarm_identifier_reg, `RESP_OK}; // RQ1
                            resp_len   = 4'h3;
                        end else if ((rx_at(p) == 8'h08
                                      && rx_at(p + 4'h1) == alarm_identifier_reg[7:0])
                                     || (rx_at(p) == 8'h10
                                      && {rx_at(p + 4'h2), rx_at(p + 4'h1)}
                                         == alarm_identifier_reg)) begin
                            resp[7:0] = `RESP_OK; // RQ8
                            resp_len  = 4'h1;
                        end
                    end
                    events[`ST_ALARM_REPLY] = (resp_len != 4'h0);
                end
                `CMD_GUARD: begin
                    resp_len = key_ok_reg ? 4'h1 : 4'h2; // RQ7
                    resp[15:0] = key_ok_reg ? {8'h00, `RESP_OK}
                                            : {`ERR_NO_KEY, `RESP_ERROR}; // RQ3
                    do_guard = key_ok_reg; // RQ2
                    events[`ST_GUARD_SET] = key_ok_reg;
                    events[`ST_REFUSED]   = !key_ok_reg;
                end
                `CMD_STORE_ID: begin
                    if (freeze_reg) begin
                        resp[15:0] = {`ERR_FROZEN, `RESP_ERROR}; // RQ9
                        resp_len   = 4'h2;
                    end else if (guard_reg && !key_ok_reg) begin
                        resp[15:0] = {`ERR_NO_KEY, `RESP_ERROR}; // RQ5
                        resp_len   = 4'h2;
                    end else begin
                        resp[7:0] = `RESP_OK; // RQ7
                        resp_len  = 4'h1;
                        do_store  = 1'b1;
                    end
                    events[`ST_ID_STORED] = do_store;
                    events[`ST_REFUSED]   = !do_store;
                end
                `CMD_FETCH_CODE: begin
                    if (!erased_reg) begin
                        resp     = {code_reg, `RESP_OK}; // RQ6
                        resp_len = 4'(`RESP_BYTES);
                        events[`ST_CODE_READ] = 1'b1;
                    end
                end
                default: resp_len = 4'h0;
            endcase
            load = (resp_len != 4'h0);
        end
    end

    // ****************************************
    // tag configuration
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            alarm_identifier_reg <= `ALARM_ID_RESET;
            guard_reg            <= 1'b0;
        end else if (do_store) begin
            alarm_identifier_reg <= {rx_at(p + 4'h1), rx_at(p)}; // RQ4
        end else if (do_guard) begin
            guard_reg <= 1'b1; // RQ2
        end else if (wr_en && addr == `OFS_CTRL && wr_data[`CTRL_GUARD] && key_ok_reg) begin
            guard_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            alarm_mode_reg <= 1'b0;
            key_ok_reg     <= 1'b0;
            freeze_reg     <= 1'b0;
            erased_reg     <= 1'b0;
        end else if (wr_en && addr == `OFS_CTRL) begin
            if (!freeze_reg) begin
                alarm_mode_reg <= wr_data[`CTRL_ALARM_MODE]; // RQ9
            end
            key_ok_reg <= wr_data[`CTRL_KEY_OK];
            freeze_reg <= freeze_reg | wr_data[`CTRL_FREEZE]; // RQ9
            erased_reg <= erased_reg | wr_data[`CTRL_ERASED];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            code_reg <= '0;
            uid_reg  <= '0;
        end else if (wr_en) begin
            case (addr)
                `OFS_CODE0:  code_reg[31:0]  <= wr_data;
                `OFS_CODE1:  code_reg[63:32] <= wr_data;
                `OFS_CODE2:  code_reg[95:64] <= wr_data;
                `OFS_UID_LO: uid_reg[31:0]   <= wr_data;
                `OFS_UID_HI: uid_reg[63:32]  <= wr_data;
                default:     uid_reg         <= uid_reg;
            endcase
        end
    end

    // ****************************************
    // status, mask, interrupt
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            status_reg <= '0;
            mask_reg   <= '0;
            irq        <= 1'b0;
        end else begin
            status_reg <= ((rd_en && addr == `OFS_STATUS) ? '0 : status_reg) | events;
            if (wr_en && addr == `OFS_MASK) begin
                mask_reg <= wr_data[`ST_WIDTH-1:0];
            end
            irq <= |(status_reg & mask_reg);
        end
    end

    // ****************************************
    // register read
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_data <= 32'h0000_0000;
        end else if (rd_en) begin
            case (addr)
                `OFS_CTRL:     rd_data <= {27'h0, guard_reg, erased_reg, freeze_reg,
                                           key_ok_reg, alarm_mode_reg};
                `OFS_STATUS:   rd_data <= {27'h0, status_reg};
                `OFS_MASK:     rd_data <= {27'h0, mask_reg};
                `OFS_ALARM_ID: rd_data <= {16'h0, alarm_identifier_reg};
                `OFS_CODE0:    rd_data <= code_reg[31:0];
                `OFS_CODE1:    rd_data <= code_reg[63:32];
                `OFS_CODE2:    rd_data <= code_reg[95:64];
                `OFS_UID_LO:   rd_data <= uid_reg[31:0];
                `OFS_UID_HI:   rd_data <= uid_reg[63:32];
                default:       rd_data <= 32'h0000_0000;
            endcase
        end else begin
            rd_data <= 32'h0000_0000;
        end
    end

    // ****************************************
    // reply output
    // ****************************************
    reply_serializer u_tx (
        .mclk     (mclk),
        .rst      (rst),
        .load     (load),
        .data     (resp),
        .len      (resp_len),
        .tx_byte  (tx_byte),
        .tx_valid (tx_valid),
        .tx_last  (tx_last),
        .busy     (tx_busy)
    );
endmodule : tag_alarm_cmd

// ==== tag_alarm_monitor.sv ====
// Purpose: port checker for tag_alarm_cmd
// Assumes: one clock, mclk
// Notes:   bound to the design at the foot
`timescale 1ns/1ps
`include "tag_alarm_params.svh"
module tag_alarm_monitor (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        rd_en,
    input wire logic [31:0] rd_data,
    input wire logic        irq,
    input wire logic        rx_eof,
    input wire logic        rx_crc_ok,
    input wire logic [7:0]  tx_byte,
    input wire logic        tx_valid,
    input wire logic        tx_last
);
    logic [3:0] run_reg;
    always_ff @(posedge mclk) begin
        if (rst || !tx_valid) run_reg <= 4'h0;
        else run_reg <= run_reg + 4'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_cause; $rose(tx_valid) |-> $past(rx_eof, 2) && $past(rx_crc_ok, 2); endproperty
    a_cause: assert property (p_cause) else $error("reply without request");
    property p_first; $rose(tx_valid) |-> tx_byte inside {`RESP_OK, `RESP_ERROR}; endproperty
    a_first: assert property (p_first) else $error("bad reply flags");
    property p_err;
        $rose(tx_valid) && tx_byte == `RESP_ERROR |-> !tx_last ##1
            tx_valid && tx_last && tx_byte inside {`ERR_NO_KEY, `ERR_FROZEN};
    endproperty
    a_err: assert property (p_err) else $error("bad error reply");
    property p_burst; tx_valid && !tx_last |=> tx_valid; endproperty
    a_burst: assert property (p_burst) else $error("reply broken");
    property p_gap; tx_last |=> !tx_valid; endproperty
    a_gap: assert property (p_gap) else $error("reply runs on");
    property p_len; tx_valid |-> run_reg < 4'd13; endproperty
    a_len: assert property (p_len) else $error("reply too long");
    property p_rd_idle; !$past(rd_en) |-> rd_data == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_quiet; $past(rst) |-> !irq && !tx_valid && rd_data == 32'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
    c_err: cover property ($rose(tx_valid) && tx_byte == `RESP_ERROR);
    c_code: cover property (tx_last && run_reg == 4'd12);
    c_irq: cover property ($rose(irq));
endmodule : tag_alarm_monitor
bind tag_alarm_cmd tag_alarm_monitor mon (.mclk(mclk), .rst(rst), .rd_en(rd_en),
    .rd_data(rd_data), .irq(irq), .rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last));

// ==== reader_model.sv ====
// Purpose: interrogator model sending request frames, collecting replies
// Assumes: crc verdict given beside end of frame
// Notes:   data line inverted when idle
`timescale 1ns/1ps
module reader_model (
    input  wire logic       mclk,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_valid,
    output logic            rx_sof,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            rx_eof,
    output logic            rx_crc_ok
);
    logic [7:0] rep[$];
    initial begin
        rx_sof = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        rx_eof = 1'b0;
        rx_crc_ok = 1'b0;
    end
    always @(posedge mclk) if (tx_valid) rep.push_back(tx_byte);
    // flags, command, maker code, optional uid, parameters
    task automatic send(input int q[$], input bit ok);
        @(posedge mclk);
        rx_sof <= 1'b1;
        foreach (q[i]) begin
            @(posedge mclk);
            rx_sof <= 1'b0;
            rx_valid <= 1'b1;
            rx_byte <= q[i][7:0];
        end
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_eof <= 1'b1;
        rx_crc_ok <= ok;
        rx_byte <= ~rx_byte;
        @(posedge mclk);
        rx_eof <= 1'b0;
        rx_crc_ok <= 1'b0;
    endtask : send
endmodule : reader_model

// ==== tb_tag_alarm_and_epc_commands.sv ====
// Purpose: self-checking bench of tag_alarm_cmd
// Assumes: reader_model at the link
// Notes:   model state kept in plain variables
`timescale 1ns/1ps
`include "tag_alarm_params.svh"
module tb_tag_alarm_and_epc_commands;
    logic        mclk = 1'b0;
    logic        rst, wr_en, rd_en, irq, rx_sof, rx_valid, rx_eof, rx_crc_ok, tx_valid, tx_last;
    logic [7:0]  addr, rx_byte, tx_byte;
    logic [31:0] wr_data, rd_data, rv, n;
    logic [15:0] id;
    logic [95:0] code;
    logic [63:0] uid;
    logic [4:0]  st, msk;
    bit          mode, key, frz, ers, guard;
    integer      seed = 32'h86d8915b;
    int          n_errors, checked, n_last, exp_q[$], q[$];
    always #4 mclk = ~mclk;
    always @(posedge mclk) if (tx_valid && tx_last) n_last++;
    tag_alarm_cmd dut (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .rx_sof(rx_sof),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok),
        .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last));
    reader_model rdr (.mclk(mclk), .tx_byte(tx_byte), .tx_valid(tx_valid), .rx_sof(rx_sof),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 rv = rd_data;
    endtask : rd
    task automatic rdst();
        rd(`OFS_STATUS);
        chk(rv, {27'h0, st});
        st = 5'h0;
    endtask : rdst
    task automatic wctl(input bit m, input bit k, input bit f, input bit e);
        if (!frz) mode = m;
        key = k;
        frz |= f;
        ers |= e;
        wr(`OFS_CTRL, {28'h0, e, f, k, m});
        rd(`OFS_CTRL);
        chk(rv, {27'h0, guard, ers, frz, key, mode});
    endtask : wctl
    task automatic err(input int c);
        exp_q = {`RESP_ERROR, c};
        st[`ST_REFUSED] = 1'b1;
    endtask : err
    task automatic predict(input bit ok);
        int p;
        int lo;
        exp_q.delete();
        lo = id[7:0];
        if (!ok || q.size() < 3 || q[2] != `MAKER_CODE) return;
        if (q[0][`FLAG_ADDRESSED])
            for (int i = 0; i < 8; i++) if (q[3 + i] != uid[i*8 +: 8]) return;
        p = q[0][`FLAG_ADDRESSED] ? 11 : 3;
        case (q[1])
            `CMD_GUARD: if (!key) err(`ERR_NO_KEY);
            else begin
                guard = 1'b1;
                st[`ST_GUARD_SET] = 1'b1;
                exp_q = {0};
            end
            `CMD_STORE_ID: if (frz) err(`ERR_FROZEN);
            else if (guard && !key) err(`ERR_NO_KEY);
            else begin
                id = {q[p+1][7:0], q[p][7:0]};
                st[`ST_ID_STORED] = 1'b1;
                exp_q = {0};
            end
            `CMD_ALARM_QUERY: if (q[0][`FLAG_OPTION] && mode) begin
                if (q[p] == 0) exp_q = {0, lo, id[15:8]};
                if (q[p] == 8 && q[p+1] == lo || q[p] == 16 && q[p+1] == lo
                    && q[p+2] == id[15:8]) exp_q = {0};
                if (exp_q.size() > 0) st[`ST_ALARM_REPLY] = 1'b1;
            end
            `CMD_FETCH_CODE: if (!ers) begin
                exp_q = {0};
                for (int i = 0; i < 12; i++) exp_q.push_back(code[i*8 +: 8]);
                st[`ST_CODE_READ] = 1'b1;
            end
            default: ;
        endcase
    endtask : predict
    task automatic go(input bit ok);
        predict(ok);
        rdr.rep.delete();
        n_last = 0;
        rdr.send(q, ok);
        repeat (20) @(posedge mclk);
        #1;
        chk(rdr.rep.size(), exp_q.size());
        chk(n_last, exp_q.size() > 0);
        foreach (exp_q[i]) if (i < rdr.rep.size()) chk(rdr.rep[i], exp_q[i]);
        chk(irq, |(st & msk));
    endtask : go
    initial begin
        repeat (100000) @(posedge mclk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        {rst, wr_en, rd_en, addr, wr_data, st, id, mode, key, frz, ers, guard} = '0;
        rst = 1'b1;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rd(`OFS_ALARM_ID);
        chk(rv, 32'h0);
        rd(8'h40);
        chk(rv, 32'h0);
        uid = {$random(seed), $random(seed)};
        code = {$random(seed), $random(seed), $random(seed)};
        wr(`OFS_UID_LO, uid[31:0]);
        wr(`OFS_UID_HI, uid[63:32]);
        for (int i = 0; i < 3; i++) wr(`OFS_CODE0 + 8'(4 * i), code[i*32 +: 32]);
        msk = 5'h1f;
        wr(`OFS_MASK, {27'h0, msk});
        q = {0, `CMD_GUARD, `MAKER_CODE};
        go(1);
        wctl(0, 1, 0, 0);
        go(1);
        $display("test guard done");
        n = $random(seed);
        q = {0, `CMD_STORE_ID, `MAKER_CODE, n[7:0], n[15:8]};
        go(1);
        rd(`OFS_ALARM_ID);
        chk(rv, {16'h0, id});
        wctl(0, 0, 0, 0);
        q[3] = q[3] ^ 255;
        go(1);
        rdst();
        msk = 5'h04;
        wr(`OFS_MASK, {27'h0, msk});
        $display("test store done");
        for (int m = 0; m < 2; m++) begin
            wctl(m, 1, 0, 0);
            q = {8'h40, `CMD_ALARM_QUERY, `MAKER_CODE, 0};
            go(1);
            q = {8'h40, `CMD_ALARM_QUERY, `MAKER_CODE, 8, id[7:0]};
            go(1);
            q[4] = q[4] ^ 1;
            go(1);
            q = {8'h40, `CMD_ALARM_QUERY, `MAKER_CODE, 16, id[7:0], id[15:8]};
            go(1);
            q[5] = q[5] ^ 1;
            go(1);
            q = {0, `CMD_ALARM_QUERY, `MAKER_CODE};
            go(1);
        end
        rdst();
        $display("test alarm done");
        q = {8'h60, `CMD_ALARM_QUERY, `MAKER_CODE};
        for (int i = 0; i < 8; i++) q.push_back(uid[i*8 +: 8]);
        q.push_back(0);
        go(1);
        q[3] = q[3] ^ 1;
        go(1);
        q = {8'h40, `CMD_ALARM_QUERY, 8'h5b, 0};
        go(1);
        q[2] = `MAKER_CODE;
        go(0);
        q[1] = 8'ha9;
        go(1);
        $display("test frame done");
        q = {0, `CMD_FETCH_CODE, `MAKER_CODE};
        go(1);
        wctl(1, 1, 0, 1);
        go(1);
        $display("test code done");
        wctl(1, 1, 1, 1);
        q = {0, `CMD_STORE_ID, `MAKER_CODE, 1, 2};
        go(1);
        wctl(0, 1, 1, 1);
        q = {8'h40, `CMD_ALARM_QUERY, `MAKER_CODE, 0};
        go(1);
        rdst();
        $display("test freeze done");
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        {st, id, mode, key, frz, ers, guard, msk} = '0;
        rdst();
        rd(`OFS_ALARM_ID);
        chk(rv, 32'h0);
        wr(`OFS_CTRL, 32'h10);
        wctl(0, 1, 0, 0);
        wr(`OFS_CTRL, 32'h12);
        guard = 1'b1;
        wctl(0, 1, 0, 0);
        $display("test reset done");
        report_and_stop();
    end
endmodule : tb_tag_alarm_and_epc_commands
